//--- rtl/scc_pkg.sv
// constants and types shared by the synchronous counter block
package scc_pkg;
    // counter geometry
    localparam int SCC_WIDTH = 4;
    localparam logic [3:0] SCC_MAX = 4'hF;
    localparam logic [3:0] SCC_RESET_VALUE = 4'h0;
    // register bus geometry
    localparam int SCC_ADDR_W = 4;
    localparam int SCC_DATA_W = 32;
    localparam int SCC_STRB_W = 4;
    // register byte offsets
    localparam logic [3:0] SCC_CTRL_OFFSET = 4'h0;
    localparam logic [3:0] SCC_STATUS_OFFSET = 4'h4;
    localparam logic [3:0] SCC_WRAPS_OFFSET = 4'h8;
    // control register fields
    localparam int SCC_CTRL_CLEAR_BIT = 0;
    localparam int SCC_CTRL_LOAD_BIT = 1;
    localparam int SCC_CTRL_GATE_P_BIT = 2;
    localparam int SCC_CTRL_GATE_T_BIT = 3;
    localparam int SCC_CTRL_VALUE_LSB = 4;
    localparam logic SCC_GATE_RESET = 1'b1;
    localparam logic [3:0] SCC_VALUE_RESET = 4'h0;
    // status register fields
    localparam int SCC_STAT_COUNT_LSB = 0;
    localparam int SCC_STAT_TC_BIT = 4;
    localparam int SCC_STAT_WRAP_BIT = 5;
    localparam int SCC_STAT_RUN_BIT = 6;
    // bus responses
    localparam logic [1:0] SCC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SCC_RESP_SLVERR = 2'h2;
    // write channel states
    typedef enum logic {SCC_WR_IDLE, SCC_WR_RESP} scc_wr_state_t;
endpackage : scc_pkg

//--- rtl/scc_bit.sv
// one stage of the synchronous counter
`timescale 1ns/1ps
module scc_bit #(
    parameter logic RESET_BIT = 1'b0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clear_n_in,
    input wire logic load_n_in,
    input wire logic load_bit_in,
    input wire logic toggle_in,
    output logic q_out
);
    import scc_pkg::*;

    logic bit_q;

    // every stage sees the shared clock, so all stages settle on the same edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_q <= RESET_BIT;
        end else if (!clear_n_in) begin
            bit_q <= 1'b0;
        end else if (!load_n_in) begin
            bit_q <= load_bit_in;
        end else if (toggle_in) begin
            bit_q <= ~bit_q;
        end else begin
            bit_q <= bit_q;
        end
    end

    assign q_out = bit_q;
endmodule : scc_bit

//--- rtl/scc_axil.sv
// register bus slave for the synchronous counter
`timescale 1ns/1ps
module scc_axil (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [scc_pkg::SCC_ADDR_W-1:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [scc_pkg::SCC_DATA_W-1:0] wdata_in,
    input wire logic [scc_pkg::SCC_STRB_W-1:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [scc_pkg::SCC_ADDR_W-1:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [scc_pkg::SCC_DATA_W-1:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    output logic wr_en_out,
    output logic [scc_pkg::SCC_ADDR_W-1:0] wr_addr_out,
    output logic [scc_pkg::SCC_DATA_W-1:0] wr_data_out,
    output logic [scc_pkg::SCC_STRB_W-1:0] wr_strb_out,
    input wire logic wr_err_in,
    output logic [scc_pkg::SCC_ADDR_W-1:0] rd_addr_out,
    input wire logic [scc_pkg::SCC_DATA_W-1:0] rd_data_in,
    input wire logic rd_err_in
);
    import scc_pkg::*;

    scc_wr_state_t wr_state_q;
    logic aw_held_q;
    logic w_held_q;
    logic [SCC_ADDR_W-1:0] addr_q;
    logic [SCC_DATA_W-1:0] data_q;
    logic [SCC_STRB_W-1:0] strb_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [SCC_DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;

    // address and data may arrive in either order; each is held until both are in
    assign awready_out = !aw_held_q && (wr_state_q == SCC_WR_IDLE);
    assign wready_out = !w_held_q && (wr_state_q == SCC_WR_IDLE);
    assign wr_en_out = aw_held_q && w_held_q && (wr_state_q == SCC_WR_IDLE);
    assign wr_addr_out = addr_q;
    assign wr_data_out = data_q;
    assign wr_strb_out = strb_q;
    assign bvalid_out = (wr_state_q == SCC_WR_RESP);
    assign bresp_out = bresp_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aw_held_q <= 1'b0;
            addr_q <= '0;
        end else if (awvalid_in && awready_out) begin
            aw_held_q <= 1'b1;
            addr_q <= awaddr_in;
        end else if (wr_en_out) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            w_held_q <= 1'b0;
            data_q <= '0;
            strb_q <= '0;
        end else if (wvalid_in && wready_out) begin
            w_held_q <= 1'b1;
            data_q <= wdata_in;
            strb_q <= wstrb_in;
        end else if (wr_en_out) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_state_q <= SCC_WR_IDLE;
            bresp_q <= SCC_RESP_OKAY;
        end else begin
            case (wr_state_q)
                SCC_WR_IDLE: begin
                    if (wr_en_out) begin
                        wr_state_q <= SCC_WR_RESP;
                        bresp_q <= wr_err_in ? SCC_RESP_SLVERR : SCC_RESP_OKAY;
                    end
                end
                SCC_WR_RESP: begin
                    if (bready_in) begin
                        wr_state_q <= SCC_WR_IDLE;
                    end
                end
                default: begin
                    wr_state_q <= SCC_WR_IDLE;
                end
            endcase
        end
    end

    // reads have no side effects, so data is sampled straight from the decode
    assign arready_out = !rvalid_q;
    assign rd_addr_out = araddr_in;
    assign rvalid_out = rvalid_q;
    assign rdata_out = rdata_q;
    assign rresp_out = rresp_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= SCC_RESP_OKAY;
        end else if (arvalid_in && arready_out) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_data_in;
            rresp_q <= rd_err_in ? SCC_RESP_SLVERR : SCC_RESP_OKAY;
        end else if (rready_in) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule : scc_axil

//--- rtl/scc_counter.sv
// four-bit synchronous counter with clear, load, two count enables and carry out
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - the counter is four bits, all stages clocked by one rising clock edge.
// - all stages change together, driven by the common clock, not by stages.
// - clear low at a rising edge zeroes every count bit at that edge only.
// - clear overrides load, counting and holding whatever the other inputs do.
// - with clear high and load low, the load value is taken at the next edge.
// - count up by one only with both enables high and no load or clear.
// - terminal carry is high while the count is fifteen and the gated trickle enable is high.
////////////////////////////////////////////////////////////////////////////////
module scc_counter #(
    parameter int WRAP_W = 16
) (
    input wire logic CORE_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic SYNC_CLEAR_N_IN,
    input wire logic LOAD_ENABLE_N_IN,
    input wire logic COUNT_ENABLE_P_IN,
    input wire logic COUNT_ENABLE_T_IN,
    input wire logic [scc_pkg::SCC_WIDTH-1:0] LOAD_VALUE_IN,
    output logic [scc_pkg::SCC_WIDTH-1:0] COUNT_VALUE_OUT,
    output logic TERMINAL_CARRY_OUT,
    input wire logic [scc_pkg::SCC_ADDR_W-1:0] S_AXI_AWADDR_IN,
    input wire logic [2:0] S_AXI_AWPROT_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [scc_pkg::SCC_DATA_W-1:0] S_AXI_WDATA_IN,
    input wire logic [scc_pkg::SCC_STRB_W-1:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [scc_pkg::SCC_ADDR_W-1:0] S_AXI_ARADDR_IN,
    input wire logic [2:0] S_AXI_ARPROT_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [scc_pkg::SCC_DATA_W-1:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN
);
    import scc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [SCC_WIDTH-1:0] count_q;
    logic [SCC_WIDTH:0] carry_chain;
    logic clear_n_eff;
    logic load_n_eff;
    logic [SCC_WIDTH-1:0] load_val_eff;
    logic enable_p_eff;
    logic enable_t_eff;
    logic count_now;
    logic wrap_evt;
    logic sw_clear_q;
    logic sw_load_q;
    logic gate_p_q;
    logic gate_t_q;
    logic [SCC_WIDTH-1:0] sw_value_q;
    logic wrap_seen_q;
    logic [WRAP_W-1:0] wraps_q;
    logic wr_en;
    logic [SCC_ADDR_W-1:0] wr_addr;
    logic [SCC_DATA_W-1:0] wr_data;
    logic [SCC_STRB_W-1:0] wr_strb;
    logic wr_err;
    logic [SCC_ADDR_W-1:0] rd_addr;
    logic [SCC_DATA_W-1:0] rd_data;
    logic rd_err;
    logic wr_ctrl;
    logic wr_status;
    logic wr_wraps;

    ////////////////////////////////////////////////////////////////////////////
    // control merge: pins and software strobes share one path
    // a software strobe lasts one cycle and acts on the edge that ends it
    assign clear_n_eff = SYNC_CLEAR_N_IN && !sw_clear_q;
    assign load_n_eff = LOAD_ENABLE_N_IN && !sw_load_q;
    // pin load wins over a software load arriving in the same cycle
    assign load_val_eff = !LOAD_ENABLE_N_IN ? LOAD_VALUE_IN : sw_value_q;
    assign enable_p_eff = COUNT_ENABLE_P_IN && gate_p_q;
    assign enable_t_eff = COUNT_ENABLE_T_IN && gate_t_q;
    assign count_now = enable_p_eff && enable_t_eff;

    ////////////////////////////////////////////////////////////////////////////
    // counter stages
    // the toggle chain is combinational, so a bit flips only when all lower
    // bits are one; no stage is clocked from another stage's output
    assign carry_chain[0] = count_now;

    for (genvar i = 0; i < SCC_WIDTH; i++) begin : g_stage
        assign carry_chain[i+1] = carry_chain[i] && count_q[i];

        scc_bit #(
            .RESET_BIT(SCC_RESET_VALUE[i])
        ) u_bit (
            .clk_in(CORE_CLK_IN),
            .rst_n_in(RESETN_IN),
            .clear_n_in(clear_n_eff),
            .load_n_in(load_n_eff),
            .load_bit_in(load_val_eff[i]),
            .toggle_in(carry_chain[i]),
            .q_out(count_q[i])
        );
    end

    // a wrap only counts when the increment really happens
    assign wrap_evt = carry_chain[SCC_WIDTH] && clear_n_eff && load_n_eff;

    assign COUNT_VALUE_OUT = count_q;
    // carry out follows the trickle enable without a clock, as a cascade needs
    assign TERMINAL_CARRY_OUT = enable_t_eff && (count_q == SCC_MAX);

    ////////////////////////////////////////////////////////////////////////////
    // register bus
    scc_axil u_axil (
        .clk_in(CORE_CLK_IN),
        .rst_n_in(RESETN_IN),
        .awaddr_in(S_AXI_AWADDR_IN),
        .awvalid_in(S_AXI_AWVALID_IN),
        .awready_out(S_AXI_AWREADY_OUT),
        .wdata_in(S_AXI_WDATA_IN),
        .wstrb_in(S_AXI_WSTRB_IN),
        .wvalid_in(S_AXI_WVALID_IN),
        .wready_out(S_AXI_WREADY_OUT),
        .bresp_out(S_AXI_BRESP_OUT),
        .bvalid_out(S_AXI_BVALID_OUT),
        .bready_in(S_AXI_BREADY_IN),
        .araddr_in(S_AXI_ARADDR_IN),
        .arvalid_in(S_AXI_ARVALID_IN),
        .arready_out(S_AXI_ARREADY_OUT),
        .rdata_out(S_AXI_RDATA_OUT),
        .rresp_out(S_AXI_RRESP_OUT),
        .rvalid_out(S_AXI_RVALID_OUT),
        .rready_in(S_AXI_RREADY_IN),
        .wr_en_out(wr_en),
        .wr_addr_out(wr_addr),
        .wr_data_out(wr_data),
        .wr_strb_out(wr_strb),
        .wr_err_in(wr_err),
        .rd_addr_out(rd_addr),
        .rd_data_in(rd_data),
        .rd_err_in(rd_err)
    );

    // protection bits carry no meaning here
    assign wr_ctrl = wr_en && (wr_addr == SCC_CTRL_OFFSET) && wr_strb[0];
    assign wr_status = wr_en && (wr_addr == SCC_STATUS_OFFSET) && wr_strb[0];
    assign wr_wraps = wr_en && (wr_addr == SCC_WRAPS_OFFSET);
    assign wr_err = (wr_addr != SCC_CTRL_OFFSET) && (wr_addr != SCC_STATUS_OFFSET) &&
                    (wr_addr != SCC_WRAPS_OFFSET);

    always_comb begin
        rd_data = '0;
        rd_err = 1'b0;
        case (rd_addr)
            SCC_CTRL_OFFSET: begin
                rd_data[SCC_CTRL_GATE_P_BIT] = gate_p_q;
                rd_data[SCC_CTRL_GATE_T_BIT] = gate_t_q;
                rd_data[SCC_CTRL_VALUE_LSB +: SCC_WIDTH] = sw_value_q;
            end
            SCC_STATUS_OFFSET: begin
                rd_data[SCC_STAT_COUNT_LSB +: SCC_WIDTH] = count_q;
                rd_data[SCC_STAT_TC_BIT] = TERMINAL_CARRY_OUT;
                rd_data[SCC_STAT_WRAP_BIT] = wrap_seen_q;
                rd_data[SCC_STAT_RUN_BIT] = count_now;
            end
            SCC_WRAPS_OFFSET: begin
                rd_data[WRAP_W-1:0] = wraps_q;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            gate_p_q <= SCC_GATE_RESET;
            gate_t_q <= SCC_GATE_RESET;
            sw_value_q <= SCC_VALUE_RESET;
        end else if (wr_ctrl) begin
            gate_p_q <= wr_data[SCC_CTRL_GATE_P_BIT];
            gate_t_q <= wr_data[SCC_CTRL_GATE_T_BIT];
            sw_value_q <= wr_data[SCC_CTRL_VALUE_LSB +: SCC_WIDTH];
        end
    end

    // strobe bits never store; they fire once per write
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            sw_clear_q <= 1'b0;
            sw_load_q <= 1'b0;
        end else begin
            sw_clear_q <= wr_ctrl && wr_data[SCC_CTRL_CLEAR_BIT];
            sw_load_q <= wr_ctrl && wr_data[SCC_CTRL_LOAD_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wrap bookkeeping: a wrap in the cycle of a clear or load does not count
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            wrap_seen_q <= 1'b0;
        end else if (wrap_evt) begin
            wrap_seen_q <= 1'b1;
        end else if (wr_status && wr_data[SCC_STAT_WRAP_BIT]) begin
            wrap_seen_q <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            wraps_q <= '0;
        end else if (wr_wraps) begin
            wraps_q <= WRAP_W'(wrap_evt);
        end else if (wrap_evt) begin
            wraps_q <= wraps_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    sequence s_clear_req;
        !clear_n_eff;
    endsequence

    sequence s_load_req;
        clear_n_eff && !load_n_eff;
    endsequence

    sequence s_inc_req;
        clear_n_eff && load_n_eff && count_now;
    endsequence

    sequence s_hold_req;
        clear_n_eff && load_n_eff && !count_now;
    endsequence

    sequence s_reach_max;
        s_inc_req ##0 (count_q == 4'hE);
    endsequence

    clear_zeroes_a: assert property (s_clear_req |=> count_q == 4'h0)
        else $error("clear did not zero the count");

    clear_not_now_a: assert property ($fell(clear_n_eff) && $past(count_q) != 4'h0 &&
        $past(count_now) == 1'b0 && $past(load_n_eff) |-> count_q != 4'h0)
        else $error("clear acted before the clock edge");

    load_copies_a: assert property (s_load_req |=> count_q == $past(load_val_eff))
        else $error("load value not taken");

    count_up_a: assert property (s_inc_req |=> count_q == 4'($past(count_q) + 4'h1))
        else $error("count did not advance by one");

    four_bit_wrap_a: assert property (s_inc_req ##0 count_q == 4'hF |=> count_q == 4'h0)
        else $error("count did not wrap from fifteen");

    hold_stable_a: assert property (s_hold_req |=> $stable(count_q))
        else $error("count moved while holding");

    no_stray_change_a: assert property (count_q != $past(count_q) |->
        $past(!clear_n_eff || !load_n_eff || count_now))
        else $error("count changed without a control");

    carry_at_max_a: assert property (s_reach_max ##1 enable_t_eff |-> TERMINAL_CARRY_OUT)
        else $error("carry missing at fifteen");

    carry_gated_a: assert property (!COUNT_ENABLE_T_IN || count_q != 4'hF
        |-> !TERMINAL_CARRY_OUT)
        else $error("carry high off maximum or without trickle enable");

    wrap_sticky_a: assert property (wrap_evt |=> wrap_seen_q)
        else $error("wrap event lost");

    bresp_holds_a: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
        S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
        else $error("write response dropped early");

    rdata_holds_a: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
        S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
        else $error("read data dropped early");

    wrap_clear_a: assert property (wr_status && wr_data[SCC_STAT_WRAP_BIT] && !wrap_evt |=>
        !wrap_seen_q)
        else $error("wrap flag not cleared by software");

    wraps_count_a: assert property (wrap_evt && !wr_wraps |=>
        wraps_q == WRAP_W'($past(wraps_q) + 1'b1))
        else $error("wrap count did not advance");

    carry_present_a: assert property (COUNT_ENABLE_T_IN && gate_t_q &&
        count_q == SCC_MAX |-> TERMINAL_CARRY_OUT)
        else $error("carry low at fifteen with trickle enable");
endmodule : scc_counter

//--- sim/scc_next_stage.sv
// next cascaded counter stage, fed from the block's terminal carry
`timescale 1ns/1ps
module scc_next_stage (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic carry_in,
    output logic [3:0] count_out
);
    // count enable p of this stage is tied high, so the carry alone advances it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_out <= 4'h0;
        end else if (carry_in) begin
            count_out <= count_out + 4'h1;
        end
    end
endmodule : scc_next_stage

//--- sim/testbench.sv
// self-checking bench for the synchronous counter and its register bus
`timescale 1ns/1ps
module testbench;
    import scc_pkg::*;
    typedef struct {logic [31:0] data; logic [31:0] mask; logic [1:0] resp;} scc_exp_t;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic clr_n = 1'h1, ld_n = 1'h1, count_enable_p = 1'h0, count_enable_t = 1'h0;
    logic [3:0] ld_val = 4'h0, awaddr = 4'h0, araddr = 4'h0, cnt, hi;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic tc, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic model_on = 1'h0, gate_p = 1'h1, gate_t = 1'h1;
    logic [3:0] exp_cnt = 4'h0, exp_hi = 4'h0;
    logic [15:0] exp_wraps = 16'h0, rnd = 16'hD8D0;
    logic [7:0] ec;
    scc_exp_t ew, er, wr_q[$], rd_q[$];
    logic [7:0] cq[$];
    int mismatches = 0;
    int n_checks = 0;
    ////////////////////////////////////////////////////////////////////////////
    scc_counter #(.WRAP_W(16)) dut_u (.CORE_CLK_IN(clk), .RESETN_IN(rst_n),
        .SYNC_CLEAR_N_IN(clr_n), .LOAD_ENABLE_N_IN(ld_n), .COUNT_ENABLE_P_IN(count_enable_p),
        .COUNT_ENABLE_T_IN(count_enable_t), .LOAD_VALUE_IN(ld_val), .COUNT_VALUE_OUT(cnt),
        .TERMINAL_CARRY_OUT(tc), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWPROT_IN(3'h0),
        .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
        .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
        .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARPROT_IN(3'h0), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready));
    scc_next_stage next_u (.clk_in(clk), .rst_n_in(rst_n), .carry_in(tc), .count_out(hi));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr_next
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out;
        if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    // expected count follows the documented priority, mirrored at each edge
    always @(posedge clk) begin
        if (model_on) begin
            if (count_enable_t && gate_t && exp_cnt == SCC_MAX) exp_hi = exp_hi + 4'h1;
            if (!clr_n) exp_cnt = 4'h0;
            else if (!ld_n) exp_cnt = ld_val;
            else if (count_enable_p && count_enable_t && gate_p && gate_t) begin
                if (exp_cnt == SCC_MAX) exp_wraps = exp_wraps + 16'h1;
                exp_cnt = exp_cnt + 4'h1;
            end
            cq.push_back({exp_hi, exp_cnt});
        end
        if (bvalid && bready) begin
            ew = wr_q.pop_front();
            chk({30'h0, bresp}, {30'h0, ew.resp});
        end
        if (rvalid && rready) begin
            er = rd_q.pop_front();
            chk(rdata & er.mask, er.data);
            chk({30'h0, rresp}, {30'h0, er.resp});
        end
    end
    // settled outputs are looked at mid-cycle; the carry is combinational
    always @(negedge clk) begin
        if (cq.size() > 0) begin
            ec = cq.pop_front();
            chk({23'h0, tc, hi, cnt}, {23'h0, count_enable_t & gate_t & (ec[3:0] == SCC_MAX), ec});
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic pins(input logic c, input logic l, input logic p, input logic t,
                        input logic [3:0] v, input int n);
        clr_n <= c;
        ld_n <= l;
        count_enable_p <= p;
        count_enable_t <= t;
        ld_val <= v;
        repeat (n) @(posedge clk);
    endtask : pins
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        wr_q.push_back('{32'h0, 32'h0, r});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awvalid && awready) aw_ok = 1'h1;
            if (wvalid && wready) w_ok = 1'h1;
            if (aw_ok) awvalid <= 1'h0;
            if (w_ok) wvalid <= 1'h0;
        end
        do @(posedge clk); while (!bvalid);
        bready <= 1'h0;
        @(posedge clk);
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m,
                          input logic [1:0] r);
        rd_q.push_back('{d, m, r});
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'h0;
        @(posedge clk);
    endtask : axi_rd
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        model_on <= 1'h1;
        axi_rd(SCC_CTRL_OFFSET, 32'h0C, 32'hFF, SCC_RESP_OKAY);
        axi_rd(SCC_STATUS_OFFSET, 32'h0, 32'h7F, SCC_RESP_OKAY);
        axi_rd(SCC_WRAPS_OFFSET, 32'h0, 32'hFFFF, SCC_RESP_OKAY);
        axi_rd(4'hC, 32'h0, 32'hFFFFFFFF, SCC_RESP_SLVERR);
        axi_wr(4'hC, 32'hFFFFFFFF, SCC_RESP_SLVERR);
        pins(1'h1, 1'h0, 1'h0, 1'h0, 4'hD, 1);
        pins(1'h0, 1'h0, 1'h1, 1'h1, 4'hA, 1);
        pins(1'h1, 1'h0, 1'h1, 1'h1, 4'hD, 1);
        pins(1'h1, 1'h1, 1'h1, 1'h1, 4'h0, 4);
        pins(1'h1, 1'h0, 1'h0, 1'h0, 4'hF, 1);
        pins(1'h1, 1'h1, 1'h0, 1'h1, 4'h0, 3);
        pins(1'h1, 1'h1, 1'h1, 1'h0, 4'h0, 2);
        pins(1'h1, 1'h0, 1'h1, 1'h1, 4'h9, 1);
        pins(1'h1, 1'h1, 1'h1, 1'h1, 4'h0, 3);
        pins(1'h0, 1'h1, 1'h1, 1'h1, 4'h0, 1);
        for (int i = 0; i < 300; i++) begin
            rnd = lfsr_next(rnd);
            pins(|rnd[2:0], |rnd[5:3], rnd[6], rnd[7], rnd[11:8], 1);
        end
        pins(1'h1, 1'h1, 1'h0, 1'h0, 4'h0, 1);
        axi_rd(SCC_WRAPS_OFFSET, {16'h0, exp_wraps}, 32'hFFFF, SCC_RESP_OKAY);
        model_on <= 1'h0;
        // software load with gate p off; the pins keep still so the mirror stays exact
        axi_wr(SCC_CTRL_OFFSET, 32'h6A, SCC_RESP_OKAY);
        exp_cnt = 4'h6;
        gate_p = 1'h0;
        model_on <= 1'h1;
        axi_rd(SCC_STATUS_OFFSET, 32'h26, 32'h7F, SCC_RESP_OKAY);
        pins(1'h1, 1'h1, 1'h1, 1'h1, 4'h0, 3);
        axi_rd(SCC_CTRL_OFFSET, 32'h68, 32'hFF, SCC_RESP_OKAY);
        pins(1'h1, 1'h1, 1'h0, 1'h0, 4'h0, 1);
        model_on <= 1'h0;
        axi_wr(SCC_CTRL_OFFSET, 32'h0D, SCC_RESP_OKAY);
        exp_cnt = 4'h0;
        gate_p = 1'h1;
        axi_wr(SCC_WRAPS_OFFSET, 32'h0, SCC_RESP_OKAY);
        model_on <= 1'h1;
        axi_rd(SCC_WRAPS_OFFSET, 32'h0, 32'hFFFF, SCC_RESP_OKAY);
        axi_rd(SCC_STATUS_OFFSET, 32'h20, 32'h7F, SCC_RESP_OKAY);
        // the wrap flag is write-one-to-clear
        axi_wr(SCC_STATUS_OFFSET, 32'h20, SCC_RESP_OKAY);
        axi_rd(SCC_STATUS_OFFSET, 32'h0, 32'h7F, SCC_RESP_OKAY);
        pins(1'h1, 1'h1, 1'h1, 1'h1, 4'h0, 2);
        axi_rd(SCC_STATUS_OFFSET, 32'h40, 32'h40, SCC_RESP_OKAY);
        // trickle enable low keeps the carry quiet while the gate write is under way
        pins(1'h1, 1'h0, 1'h0, 1'h0, 4'hF, 1);
        model_on <= 1'h0;
        axi_wr(SCC_CTRL_OFFSET, 32'h04, SCC_RESP_OKAY);
        gate_t = 1'h0;
        model_on <= 1'h1;
        pins(1'h1, 1'h1, 1'h1, 1'h1, 4'h0, 3);
        close_out();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        close_out();
    end
endmodule : testbench
